// >>> bridge_ctrl.sv
// Purpose: Serial-controlled GPIB bridge: buffers, turnaround, flow control, boot and self test
// Assumes: Inputs synchronous to pclk; GPIB handshake abstracted to valid/ready bytes
// Notes:   APB slave with zero wait states; read data is captured in the setup cycle
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
module bridge_ctrl #(
	parameter int unsigned TURN_IDLE_CYC = bridge_pkg::TURN_IDLE_CYC,
	parameter int unsigned IFC_CYC       = bridge_pkg::IFC_CYC,
	parameter int unsigned SELFTEST_CYC  = bridge_pkg::SELFTEST_CYC,
	parameter int unsigned ADDR_SHOW_CYC = bridge_pkg::ADDR_SHOW_CYC
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        ser_rx_valid,
	input  wire logic [7:0]  ser_rx_data,
	input  wire logic        ser_connected,
	output logic             ser_tx_valid,
	input  wire logic        ser_tx_ready,
	output logic [7:0]       ser_tx_data,
	output logic             ser_rts,
	output logic             gpib_tx_valid,
	input  wire logic        gpib_tx_ready,
	output logic [7:0]       gpib_tx_data,
	input  wire logic        gpib_rx_valid,
	input  wire logic        gpib_rx_cmd,
	input  wire logic [7:0]  gpib_rx_data,
	output logic             gpib_rx_ready,
	output logic             gpib_ren,
	output logic             gpib_ifc,
	output logic             addr_req,
	output logic             addr_talk,
	output logic [4:0]       addr_value,
	output logic             srq,
	input  wire logic [10:0] nv_cfg,
	output logic             nv_wr,
	output logic [10:0]      nv_wdata,
	input  wire logic [4:0]  test_fault,
	input  wire logic        fatal_cpu,
	input  wire logic        fatal_all,
	input  wire logic        power_fault,
	output logic [5:0]       leds,
	output logic             st_resp_valid,
	output logic [4:0]       st_resp_code
);
	import bridge_pkg::*;

	localparam int unsigned AW = BUF_AW;

	bridge_pkg::boot_t          state_q;
	logic [bridge_pkg::TM_W-1:0] tm_q;
	logic [bridge_pkg::TM_W-1:0] idle_q;
	logic [23:0]                blink_q;
	logic [bridge_pkg::CFG_W-1:0] cfg_q;
	logic                       loaded_q;
	logic [4:0]                 fault_q;
	logic [2:0]                 fatal_q;
	logic                       dir_q;
	logic                       stop_q;
	logic                       sent_q;
	logic [2:0]                 ev_q;
	logic [31:0]                prdata_q;
	logic                       addr_req_q;
	logic                       addr_talk_q;
	logic [4:0]                 addr_value_q;
	logic                       nv_wr_q;
	logic [10:0]                nv_wdata_q;
	logic                       st_resp_valid_q;
	logic [4:0]                 st_resp_code_q;
	logic [5:0]                 leds_q;
	logic [bridge_pkg::TM_W-1:0] ifc_len_q;

	logic [1:0]  turn;
	logic [4:0]  gaddr;
	logic        xon_en;
	logic [2:0]  srq_en;
	logic [7:0]  term;
	logic        run;
	logic        can_turn;
	logic        reverse;
	logic        restore;
	logic        s_full, s_empty, s_rd_valid, s_wr_ready;
	logic [7:0]  s_rd_data;
	logic [AW:0] s_level;
	logic        g_full, g_empty, g_rd_valid, g_wr_ready, g_rd_ready;
	logic [7:0]  g_rd_data;
	logic [AW:0] g_level;
	logic        flow_pend;
	logic        gtx_fire;
	logic        cmd_fire;
	logic        apb_wr;
	logic        apb_setup;
	logic        mapped;
	logic        timeout_hit;
	logic        term_hit;
	logic [2:0]  blink_mask;

	// Working configuration fields, one turnaround method by encoding
	assign turn    = cfg_q[CFG_TURN_LSB +: 2];
	assign gaddr   = cfg_q[CFG_ADDR_LSB +: 5];
	assign xon_en  = cfg_q[CFG_XON_BIT];
	assign srq_en  = cfg_q[CFG_SRQ_LSB +: 3];
	assign term    = (turn == TURN_CR) ? CH_CR : CH_LF;
	assign run     = (state_q == ST_RUN);
	assign can_turn = run && (turn != TURN_NONE) && (gaddr != ADDR_TALK_ONLY);

	// Serial-to-GPIB buffer; writes while full are dropped
	circ_buf #(.AW(AW)) u_ser_buf (
		.clk      (pclk),
		.rst_n    (presetn),
		.wr_valid (ser_rx_valid),
		.wr_data  (ser_rx_data),
		.wr_ready (s_wr_ready),
		.rd_valid (s_rd_valid),
		.rd_data  (s_rd_data),
		.rd_ready (gpib_tx_ready && run && !dir_q),
		.level    (s_level),
		.full     (s_full),
		.empty    (s_empty)
	);

	// GPIB-to-serial buffer; data bytes only
	circ_buf #(.AW(AW)) u_gpib_buf (
		.clk      (pclk),
		.rst_n    (presetn),
		.wr_valid (gpib_rx_valid && !gpib_rx_cmd),
		.wr_data  (gpib_rx_data),
		.wr_ready (g_wr_ready),
		.rd_valid (g_rd_valid),
		.rd_data  (g_rd_data),
		.rd_ready (g_rd_ready),
		.level    (g_level),
		.full     (g_full),
		.empty    (g_empty)
	);

	// GPIB side handshakes; full buffer holds the bus instead of losing a byte
	assign gpib_tx_valid = s_rd_valid && run && !dir_q;
	assign gpib_tx_data  = s_rd_data;
	assign gpib_rx_ready = gpib_rx_cmd || g_wr_ready;
	assign gtx_fire      = gpib_tx_valid && gpib_tx_ready;
	assign cmd_fire      = gpib_rx_valid && gpib_rx_cmd;

	// Serial output: pending stop/resume character goes ahead of data
	assign flow_pend    = xon_en && (sent_q != stop_q);
	assign ser_tx_valid = flow_pend || g_rd_valid;
	assign ser_tx_data  = flow_pend ? (stop_q ? CH_XOFF : CH_XON) : g_rd_data;
	assign g_rd_ready   = ser_tx_ready && !flow_pend;
	assign ser_rts      = !stop_q;

	// Turnaround triggers
	assign timeout_hit = (turn == TURN_TIMEOUT) && s_empty && !ser_rx_valid
		&& (idle_q == TM_W'(TURN_IDLE_CYC));
	assign term_hit    = ((turn == TURN_CR) || (turn == TURN_LF)) && gtx_fire
		&& (gpib_tx_data == term);
	assign reverse     = can_turn && !dir_q && (timeout_hit || term_hit);
	assign restore     = dir_q && ser_rx_valid;

	// Boot sequence: self test, address display, IFC pulse, listen address
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= ST_TEST;
			tm_q    <= '0;
		end else begin
			unique case (state_q)
				ST_TEST: begin
					if (fatal_cpu || fatal_all || power_fault) begin
						state_q <= ST_FAIL;
					end else if (tm_q == TM_W'(SELFTEST_CYC - 1)) begin
						tm_q    <= '0;
						state_q <= (test_fault != 5'h00) ? ST_FAIL : ST_SHOW;
					end else begin
						tm_q <= tm_q + 1'b1;
					end
				end
				ST_SHOW: begin
					if (tm_q == TM_W'(ADDR_SHOW_CYC - 1)) begin
						tm_q    <= '0;
						state_q <= ST_IFC;
					end else begin
						tm_q <= tm_q + 1'b1;
					end
				end
				ST_IFC: begin
					if (tm_q == TM_W'(IFC_CYC - 1)) begin
						tm_q    <= '0;
						state_q <= ST_ADDR;
					end else begin
						tm_q <= tm_q + 1'b1;
					end
				end
				ST_ADDR: state_q <= ST_RUN;
				ST_RUN:  state_q <= ST_RUN;
				ST_FAIL: state_q <= ST_FAIL;
			endcase
		end
	end

	// Fault capture during test; query answers from this
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_q <= 5'h00;
			fatal_q <= 3'h0;
		end else if (state_q == ST_TEST) begin
			fault_q <= test_fault;
			fatal_q <= fatal_q | {power_fault, fatal_all, fatal_cpu};
		end
	end

	// REN from IFC onward, IFC only for its own state
	assign gpib_ren = (state_q == ST_IFC) || (state_q == ST_ADDR) || run;
	assign gpib_ifc = (state_q == ST_IFC);

	// IFC width counted apart from the sequencer, so its check does not lean on tm_q
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ifc_len_q <= '0;
		end else if (gpib_ifc) begin
			ifc_len_q <= ifc_len_q + 1'b1;
		end else begin
			ifc_len_q <= '0;
		end
	end

	// Nonvolatile copy taken once after reset release, not inside the reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cfg_q    <= CFG_RST;
			loaded_q <= 1'b0;
		end else if (!loaded_q) begin
			cfg_q    <= nv_cfg;
			loaded_q <= 1'b1;
		end else if (apb_wr && (paddr == OFF_CFG)) begin
			cfg_q <= pwdata[CFG_W-1:0];
		end
	end

	// Command parser: store settings and self-test query
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nv_wr_q         <= 1'b0;
			nv_wdata_q      <= 11'h000;
			st_resp_valid_q <= 1'b0;
			st_resp_code_q  <= 5'h00;
		end else begin
			nv_wr_q         <= cmd_fire && (gpib_rx_data == CMD_STORE);
			st_resp_valid_q <= cmd_fire && (gpib_rx_data == CMD_SELFTEST);
			if (cmd_fire && (gpib_rx_data == CMD_STORE)) begin
				nv_wdata_q <= cfg_q;
			end
			if (cmd_fire && (gpib_rx_data == CMD_SELFTEST)) begin
				st_resp_code_q <= fault_q;
			end
		end
	end

	// Serial silence counter, saturating so it cannot wrap past the threshold
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			idle_q <= '0;
		end else if (ser_rx_valid || !s_empty) begin
			idle_q <= '0;
		end else if (idle_q != TM_W'(TURN_IDLE_CYC)) begin
			idle_q <= idle_q + 1'b1;
		end
	end

	// Direction and addressing; a new character while talking restores listen, but does not block a terminator turnaround
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dir_q        <= 1'b0;
			addr_req_q   <= 1'b0;
			addr_talk_q  <= 1'b0;
			addr_value_q <= 5'h00;
		end else begin
			addr_req_q   <= restore || reverse || (state_q == ST_ADDR);
			addr_talk_q  <= reverse && !restore;
			addr_value_q <= gaddr;
			if (restore) begin
				dir_q <= 1'b0;
			end else if (reverse) begin
				dir_q <= 1'b1;
			end
		end
	end

	// Serial throttle with hysteresis; overflow beyond full is dropped by the buffer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stop_q <= 1'b0;
			sent_q <= 1'b0;
		end else begin
			if (s_level >= STOP_LVL) begin
				stop_q <= 1'b1;
			end else if (s_level <= RESUME_LVL) begin
				stop_q <= 1'b0;
			end
			if (!xon_en) begin
				sent_q <= stop_q;
			end else if (flow_pend && ser_tx_ready) begin
				sent_q <= stop_q;
			end
		end
	end

	// Sticky service-request events; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ev_q <= 3'h0;
		end else begin
			ev_q <= (ev_q & ~((apb_wr && (paddr == OFF_EVENT)) ? pwdata[2:0] : 3'h0))
				| {s_full, ser_rx_valid && (ser_rx_data == term), ser_rx_valid};
		end
	end
	assign srq = |(ev_q & srq_en);

	// Free-running blink timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			blink_q <= 24'h000000;
		end else begin
			blink_q <= blink_q + 1'b1;
		end
	end

	// Blinking indicators per fault weight: ready, talk, listener
	assign blink_mask = {fault_q[3] | fault_q[4], fault_q[1] | fault_q[2],
		fault_q[0] | fault_q[2] | fault_q[4]};

	// Indicators: power, ready, talk, listener, busy, full (left to right)
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			leds_q <= 6'h00;
		end else begin
			unique case (state_q)
				ST_TEST: leds_q <= 6'h20;
				ST_FAIL: begin
					if (fatal_q[2]) begin
						leds_q <= 6'h00;
					end else if (fatal_q[1]) begin
						leds_q <= 6'h3f;
					end else if (fatal_q[0]) begin
						leds_q <= 6'h20;
					end else begin
						leds_q <= {1'b1, blink_mask[0] & blink_q[BLINK_SLOW],
							blink_mask[1] & blink_q[BLINK_SLOW],
							blink_mask[2] & blink_q[BLINK_SLOW], 2'b00};
					end
				end
				ST_SHOW: leds_q <= {1'b1, gaddr};
				ST_IFC, ST_ADDR, ST_RUN: begin
					leds_q <= {2'b11, !dir_q, dir_q,
						ser_connected ? !s_empty : blink_q[BLINK_FAST],
						s_full || g_full};
				end
			endcase
		end
	end

	// APB slave: no wait states, error on unmapped offsets
	assign apb_setup = psel && !penable;
	assign apb_wr    = psel && penable && pwrite;
	assign mapped    = (paddr == OFF_CFG) || (paddr == OFF_STAT) || (paddr == OFF_LEVEL)
		|| (paddr == OFF_EVENT);
	assign pready    = 1'b1;
	assign pslverr   = psel && penable && !mapped;
	assign prdata    = prdata_q;

	// Read data sampled in setup so the access phase sees a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (apb_setup) begin
			unique case (paddr)
				OFF_CFG:   prdata_q <= {21'h000000, cfg_q};
				OFF_STAT:  prdata_q <= {11'h000, fault_q, 8'h00, dir_q, s_full, s_empty,
					g_full, g_empty, stop_q, run, state_q == ST_FAIL};
				OFF_LEVEL: prdata_q <= {16'(g_level), 16'(s_level)};
				OFF_EVENT: prdata_q <= {29'h00000000, ev_q};
				default:   prdata_q <= 32'h00000000;
			endcase
		end
	end

	assign addr_req      = addr_req_q;
	assign addr_talk     = addr_talk_q;
	assign addr_value    = addr_value_q;
	assign nv_wr         = nv_wr_q;
	assign nv_wdata      = nv_wdata_q;
	assign st_resp_valid = st_resp_valid_q;
	assign st_resp_code  = st_resp_code_q;
	assign leds          = leds_q;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	property p_turn_timeout;
		reverse && timeout_hit && !restore |=> dir_q && addr_req && addr_talk;
	endproperty
	a_turn_timeout: assert property (p_turn_timeout) else $error("timeout turnaround missed");

	property p_turn_term;
		can_turn && !dir_q && term_hit && !ser_rx_valid |=> dir_q && addr_talk;
	endproperty
	a_turn_term: assert property (p_turn_term) else $error("terminator turnaround missed");

	property p_restore;
		dir_q && ser_rx_valid |=> !dir_q && addr_req && !addr_talk;
	endproperty
	a_restore: assert property (p_restore) else $error("direction not restored");

	property p_no_turn;
		!can_turn && !dir_q |=> !dir_q;
	endproperty
	a_no_turn: assert property (p_no_turn) else $error("reversed without permission");

	property p_ser_keep;
		s_full && !(gpib_tx_valid && gpib_tx_ready) |=> s_level == $past(s_level);
	endproperty
	a_ser_keep: assert property (p_ser_keep) else $error("full serial buffer changed");

	property p_gpib_hold;
		g_full && !gpib_rx_cmd |-> !gpib_rx_ready;
	endproperty
	a_gpib_hold: assert property (p_gpib_hold) else $error("handshake while gpib buffer full");

	property p_rts;
		s_level >= STOP_LVL |=> !ser_rts;
	endproperty
	a_rts: assert property (p_rts) else $error("sender not throttled");

	property p_store;
		cmd_fire && gpib_rx_data == CMD_STORE |=> nv_wr && nv_wdata == $past(cfg_q) ##1 !nv_wr;
	endproperty
	a_store: assert property (p_store) else $error("store command not written");

	property p_ifc;
		$fell(gpib_ifc) |-> gpib_ren && (ifc_len_q >= TM_W'(IFC_CYC));
	endproperty
	a_ifc: assert property (p_ifc) else $error("ifc pulse too short");

	property p_show;
		state_q == ST_SHOW ##1 state_q == ST_SHOW |-> leds == {1'b1, gaddr};
	endproperty
	a_show: assert property (p_show) else $error("address not displayed");

	c_reverse: cover property (reverse);
	c_restore: cover property (restore);
	c_fail:    cover property (state_q == ST_FAIL);
	c_store:   cover property (nv_wr);
endmodule : bridge_ctrl

// >>> bridge_pkg.sv
// Purpose: Shared constants for the serial/GPIB bridge controller
// Assumes: 50 MHz pclk, APB register access, 8-bit characters
// Notes:   Offsets, field positions, reset values and timing counts live here
package bridge_pkg;
	// Clock and documented times
	localparam int unsigned CLK_HZ        = 50_000_000;
	localparam int unsigned TURN_IDLE_MS  = 300;
	localparam int unsigned IFC_US        = 100;
	localparam int unsigned SELFTEST_S    = 5;
	localparam int unsigned ADDR_SHOW_MS  = 1000;
	// Least times round up, in cycles
	localparam int unsigned TURN_IDLE_CYC = (TURN_IDLE_MS * (CLK_HZ / 1000) + 0);
	localparam int unsigned IFC_CYC       = IFC_US * (CLK_HZ / 1_000_000); // Scale first, product overflows 32 bits
	localparam int unsigned SELFTEST_CYC  = SELFTEST_S * CLK_HZ;
	localparam int unsigned ADDR_SHOW_CYC = ADDR_SHOW_MS * (CLK_HZ / 1000);
	localparam int unsigned TM_W          = 28;
	localparam int unsigned BLINK_SLOW    = 23;
	localparam int unsigned BLINK_FAST    = 20;
	// Buffers: two halves of an 8K x 8 memory
	localparam int unsigned BUF_AW        = 12;
	localparam logic [BUF_AW:0] STOP_LVL   = 13'h0fc0;
	localparam logic [BUF_AW:0] RESUME_LVL = 13'h0800;
	// APB register byte offsets
	localparam logic [7:0] OFF_CFG   = 8'h00;
	localparam logic [7:0] OFF_STAT  = 8'h04;
	localparam logic [7:0] OFF_LEVEL = 8'h08;
	localparam logic [7:0] OFF_EVENT = 8'h0c;
	// Working configuration layout
	localparam int unsigned CFG_W       = 11;
	localparam int unsigned CFG_TURN_LSB = 0;
	localparam int unsigned CFG_ADDR_LSB = 2;
	localparam int unsigned CFG_XON_BIT  = 7;
	localparam int unsigned CFG_SRQ_LSB  = 8;
	localparam logic [CFG_W-1:0] CFG_RST = 11'h014;
	localparam logic [4:0] ADDR_TALK_ONLY = 5'h1f;
	// Event bits
	localparam int unsigned EV_CHAR = 0;
	localparam int unsigned EV_MSG  = 1;
	localparam int unsigned EV_FULL = 2;
	// Characters and command bytes
	localparam logic [7:0] CH_CR   = 8'h0d;
	localparam logic [7:0] CH_LF   = 8'h0a;
	localparam logic [7:0] CH_XON  = 8'h11;
	localparam logic [7:0] CH_XOFF = 8'h13;
	localparam logic [7:0] CMD_STORE    = 8'h01;
	localparam logic [7:0] CMD_SELFTEST = 8'h02;
	// Turnaround methods: a 2-bit code selects exactly one
	typedef enum logic [1:0] {
		TURN_TIMEOUT = 2'h0,
		TURN_CR      = 2'h1,
		TURN_LF      = 2'h2,
		TURN_NONE    = 2'h3
	} turn_t;
	// Power-on sequence
	typedef enum logic [5:0] {
		ST_TEST = 6'b000001,
		ST_SHOW = 6'b000010,
		ST_IFC  = 6'b000100,
		ST_ADDR = 6'b001000,
		ST_RUN  = 6'b010000,
		ST_FAIL = 6'b100000
	} boot_t;
endpackage : bridge_pkg

// >>> circ_buf.sv
// Purpose: Circular byte buffer with honest full and empty flags
// Assumes: One clock, asynchronous active-low reset
// Notes:   Writes while full are dropped, never overwrite stored data
module circ_buf #(
	parameter int unsigned AW = bridge_pkg::BUF_AW
) (
	input  wire logic          clk,
	input  wire logic          rst_n,
	input  wire logic          wr_valid,
	input  wire logic [7:0]    wr_data,
	output logic               wr_ready,
	output logic               rd_valid,
	output logic [7:0]         rd_data,
	input  wire logic          rd_ready,
	output logic [AW:0]        level,
	output logic               full,
	output logic               empty
);
	localparam logic [AW:0] DEPTH = (AW+1)'(1 << AW);

	logic [7:0]  mem [0:(1<<AW)-1];
	logic [AW:0] wp_q;
	logic [AW:0] rp_q;
	logic        wr_fire;
	logic        rd_fire;

	// Extra pointer bit tells full from empty
	assign level    = wp_q - rp_q;
	assign full     = (level == DEPTH);
	assign empty    = (level == '0);
	assign wr_ready = !full;
	assign rd_valid = !empty;
	assign rd_data  = mem[rp_q[AW-1:0]];
	assign wr_fire  = wr_valid && !full;
	assign rd_fire  = rd_ready && !empty;

	// Storage has no reset; only pointers matter
	always_ff @(posedge clk) begin
		if (wr_fire) begin
			mem[wp_q[AW-1:0]] <= wr_data;
		end
	end

	// Pointer advance
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (wr_fire) begin
				wp_q <= wp_q + 1'b1;
			end
			if (rd_fire) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule : circ_buf

// >>> gpib_dev.sv
// Purpose: Behavioural GPIB instrument facing the bridge
// Assumes: Byte handshake abstracted to valid/ready at pclk edges
// Notes:   Slow listener: ready toggles every cycle
module gpib_dev (
	input  wire logic       pclk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	output logic            tx_ready,
	input  wire logic       rx_ready,
	output logic            rx_valid,
	output logic            rx_cmd,
	output logic [7:0]      rx_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] got[$];
	initial begin
		tx_ready = 1'b0;
		rx_valid = 1'b0;
		rx_cmd = 1'b0;
		rx_data = 8'h00;
	end
	// Record accepted bytes; stalling exercises the handshake wait
	always @(posedge pclk) begin
		if (tx_valid && tx_ready)
			got.push_back(tx_data);
		tx_ready <= ~tx_ready;
	end
	// Talk one byte, held until the bridge has room
	task send(input logic cmd, input logic [7:0] d);
		@(posedge pclk);
		rx_valid <= 1'b1;
		rx_cmd <= cmd;
		rx_data <= d;
		@(posedge pclk);
		while (!rx_ready) @(posedge pclk);
		rx_valid <= 1'b0;
		rx_data <= ~d;
	endtask : send
endmodule : gpib_dev

// >>> tb_top.sv
// Purpose: Self-checking bench for the bridge controller
// Assumes: Shortened boot and idle counts
// Notes:   Serial buffer is filled to refusal while the sequencer is parked in the fail state
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, ser_rx_valid, ser_tx_valid, ser_tx_ready, ser_rts;
	logic gpib_tx_valid, gpib_tx_ready, gpib_rx_valid, gpib_rx_cmd, gpib_rx_ready, gpib_ren, gpib_ifc;
	logic addr_req, addr_talk, srq, nv_wr, st_resp_valid, last_talk;
	logic ser_connected, fatal_cpu, fatal_all, power_fault;
	logic [7:0] paddr, ser_rx_data, ser_tx_data, gpib_tx_data, gpib_rx_data, sq;
	logic [31:0] pwdata, prdata, rd;
	logic [10:0] nv_cfg, nv_wdata, nvq;
	logic [5:0] leds;
	logic [4:0] addr_value, last_av, st_resp_code, code, test_fault;
	int n_errors = 0, checked = 0, n_addr = 0, n_ifc = 0, n_nv = 0, cyc = 0;
	bridge_ctrl #(.TURN_IDLE_CYC(20), .IFC_CYC(5), .SELFTEST_CYC(50), .ADDR_SHOW_CYC(10)) bridge_ctrl_inst (
		.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.ser_rx_valid, .ser_rx_data, .ser_connected, .ser_tx_valid, .ser_tx_ready, .ser_tx_data, .ser_rts,
		.gpib_tx_valid, .gpib_tx_ready, .gpib_tx_data, .gpib_rx_valid, .gpib_rx_cmd, .gpib_rx_data, .gpib_rx_ready,
		.gpib_ren, .gpib_ifc, .addr_req, .addr_talk, .addr_value, .srq, .nv_cfg, .nv_wr, .nv_wdata,
		.test_fault, .fatal_cpu, .fatal_all, .power_fault, .leds, .st_resp_valid, .st_resp_code);
	gpib_dev gpib_dev_inst (.pclk, .tx_valid(gpib_tx_valid), .tx_data(gpib_tx_data), .tx_ready(gpib_tx_ready),
		.rx_ready(gpib_rx_ready), .rx_valid(gpib_rx_valid), .rx_cmd(gpib_rx_cmd), .rx_data(gpib_rx_data));
	always #10 pclk = ~pclk;
	// Monitor of pulses and serial output; serial sink stalls every other cycle
	always @(posedge pclk) begin
		if (addr_req) begin
			n_addr++;
			last_talk = addr_talk;
			last_av = addr_value;
		end
		if (ser_tx_valid && ser_tx_ready) sq = ser_tx_data;
		if (gpib_ifc && gpib_ren) n_ifc++;
		if (nv_wr) begin
			n_nv++;
			nvq = nv_wdata;
		end
		if (st_resp_valid) code = st_resp_code;
		ser_tx_ready <= ~ser_tx_ready;
		cyc++;
		if (cyc == 12000) begin
			n_errors++;
			complete_run();
		end
	end
	task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (!pready) @(posedge pclk);
		rd = prdata;
		if (!wr) chk("slverr", {31'h0, pslverr}, {31'h0, a > 8'h0c});
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task ser(input logic [7:0] d);
		@(posedge pclk);
		ser_rx_valid <= 1'b1;
		ser_rx_data <= d;
		@(posedge pclk);
		ser_rx_valid <= 1'b0;
		ser_rx_data <= ~d;
		repeat (40) @(posedge pclk);
	endtask : ser
	// Mid-run reset held two cycles, with the self-test inputs set for the next boot
	task rst(input logic [4:0] tf, input logic [2:0] fat);
		@(posedge pclk);
		presetn <= 1'b0;
		test_fault <= tf;
		{power_fault, fatal_all, fatal_cpu} <= fat;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
	endtask : rst
	task complete_run;
		$display("errors %0d checks %0d", n_errors, checked);
		if (n_errors == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : complete_run
	initial begin
		pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0; paddr = 8'h00; pwdata = 32'h0;
		ser_rx_valid = 0; ser_rx_data = 8'h00; ser_tx_ready = 0; nv_cfg = 11'h115;
		ser_connected = 1; test_fault = 5'h00; fatal_cpu = 0; fatal_all = 0; power_fault = 0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		#1 chk("leds_boot", leds, 6'h20);
		apb(0, 8'h00, 0);
		chk("cfg", rd, 32'h115);
		repeat (100) begin
			apb(0, 8'h04, 0);
			if (rd[1] === 1'b1) break;
		end
		chk("ifc", n_ifc, 5);
		chk("listen", {n_addr, last_talk, last_av}, {32'd1, 1'b0, 5'd5});
		chk("ready", leds[5:4], 2'b11);
		chk("fault", rd[20:16], 5'h00);
		ser(8'h41);
		ser(bridge_pkg::CH_CR);
		chk("gpib_out", {gpib_dev_inst.got[0], gpib_dev_inst.got[1]}, 16'h410d);
		chk("cr_turn", {n_addr, last_talk}, {32'd2, 1'b1});
		chk("srq", srq, 1'b1);
		apb(1, 8'h0c, 32'h7);
		#1 chk("srq_clr", srq, 1'b0);
		gpib_dev_inst.send(1'b0, 8'h5a);
		gpib_dev_inst.send(1'b1, bridge_pkg::CMD_SELFTEST);
		repeat (10) @(posedge pclk);
		chk("ser_out", sq, 8'h5a);
		chk("query", code, 5'h00);
		ser(8'h42);
		chk("back", {n_addr, last_talk}, {32'd3, 1'b0});
		apb(1, 8'h00, 32'h114);
		chk("no_store", n_nv, 0);
		gpib_dev_inst.send(1'b1, bridge_pkg::CMD_STORE);
		repeat (40) @(posedge pclk);
		chk("store", {n_nv, nvq}, {32'd1, 11'h114});
		chk("idle_turn", {n_addr, last_talk}, {32'd4, 1'b1});
		apb(1, 8'h00, 32'h117);
		ser(8'h43);
		repeat (40) @(posedge pclk);
		chk("none", {n_addr, last_talk}, {32'd5, 1'b0});
		apb(0, 8'h10, 0);
		chk("unmapped", rd, 32'h0);
		// Failed self test parks the sequencer, so the serial buffer never drains
		rst(5'h04, 3'b000);
		repeat (60) @(posedge pclk);
		gpib_dev_inst.send(1'b1, bridge_pkg::CMD_SELFTEST);
		repeat (3) @(posedge pclk);
		chk("fault_code", code, 5'h04);
		chk("fault_leds", leds, 6'h20);
		apb(0, 8'h04, 0);
		chk("fault_stat", {rd[20:16], rd[1:0]}, {5'h04, 2'b01});
		repeat (4100) begin
			@(posedge pclk);
			ser_rx_valid <= 1'b1;
			ser_rx_data <= 8'h30;
		end
		@(posedge pclk);
		ser_rx_valid <= 1'b0;
		@(posedge pclk);
		chk("rts", ser_rts, 1'b0);
		apb(0, 8'h08, 0);
		chk("full_level", rd, 32'h00001000);
		apb(0, 8'h0c, 0);
		chk("full_event", rd, 32'h5);
		// Fatal faults: fixed patterns one edge after the sequencer lands in fail
		rst(5'h00, 3'b010);
		repeat (2) @(posedge pclk);
		#1 chk("fatal_all", leds, 6'h3f);
		rst(5'h00, 3'b100);
		repeat (2) @(posedge pclk);
		#1 chk("fatal_pwr", leds, 6'h00);
		rst(5'h00, 3'b001);
		repeat (2) @(posedge pclk);
		apb(0, 8'h04, 0);
		chk("fatal_cpu", {leds, rd[0]}, {6'h20, 1'b1});
		complete_run();
	end
endmodule : tb_top
